// >>> verilog/lmc_pkg.sv
package lmc_pkg;

    // Register byte addresses on the host configuration port.
    localparam logic [7:0] LMC_ADDR_MODE = 8'h20;
    localparam logic [7:0] LMC_ADDR_TERM = 8'h32;
    localparam logic [7:0] LMC_ADDR_LINE = 8'h40;
    localparam logic [7:0] LMC_ADDR_STAT = 8'h41;

    // carrier_and_format_select fields.
    localparam int LMC_MODE_FAMILY_BIT = 0;
    localparam int LMC_MODE_REGION_BIT = 1;
    localparam int LMC_MODE_FMT_LSB = 2;
    localparam logic [7:0] LMC_MODE_MASK = 8'h0F;
    localparam logic [7:0] LMC_MODE_RST = 8'h00;

    // Receive termination field.
    localparam int LMC_TERM_EXT_BIT = 2;
    localparam int LMC_TERM_SEL_LSB = 0;
    localparam logic [7:0] LMC_TERM_MASK = 8'h07;
    localparam logic [7:0] LMC_TERM_RST = 8'h00;

    // Line code and system side options.
    localparam int LMC_LINE_AMI_BIT = 0;
    localparam int LMC_LINE_BPV_BIT = 1;
    localparam int LMC_LINE_RATE_BIT = 2;
    localparam int LMC_LINE_BUS_BIT = 3;
    localparam logic [7:0] LMC_LINE_MASK = 8'h0F;
    localparam logic [7:0] LMC_LINE_RST = 8'h00;

    // Read-only status fields.
    localparam int LMC_STAT_FAM_LSB = 0;
    localparam int LMC_STAT_FMT_LSB = 2;
    localparam int LMC_STAT_RSVD_BIT = 5;
    localparam int LMC_STAT_INTM_BIT = 6;

    // Frame format field codes.
    localparam logic [1:0] LMC_FMT_SF = 2'h0;
    localparam logic [1:0] LMC_FMT_ESF = 2'h1;
    localparam logic [1:0] LMC_FMT_DM = 2'h2;
    localparam logic [1:0] LMC_FMT_SLC96 = 2'h3;

    // Status encoding of the family.
    localparam logic [1:0] LMC_FAM_CODE_E1 = 2'h0;
    localparam logic [1:0] LMC_FAM_CODE_T1 = 2'h1;
    localparam logic [1:0] LMC_FAM_CODE_J1 = 2'h2;

    // Synchroniser idle value: strobes high, address and data zero.
    localparam logic [18:0] LMC_PIN_IDLE = 19'h70000;

    typedef enum logic [1:0] {LMC_E1, LMC_T1, LMC_J1} lmc_family_t;
    typedef enum logic [2:0] {LMC_FR_NONE, LMC_FR_SF, LMC_FR_ESF, LMC_FR_DM, LMC_FR_SLC96} lmc_frame_t;
    typedef enum logic [1:0] {LMC_CODE_AMI, LMC_CODE_B8ZS, LMC_CODE_HDB3} lmc_code_t;

endpackage

// >>> verilog/lmc_sync2.sv
`timescale 1ns/10ps
module lmc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= RESET_VAL;
            q_reg <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule // lmc_sync2

// >>> verilog/lmc_line_mode_config.sv
// Notes on behaviour
// - Mode comes only from family, region, format.
// - T1: format selects SF, ESF, DM, SLC-96.
// - J1: only SF and ESF formats.
// - Family zero means E1; others ignored.
// - Termination upper bit clear enables internal matching.
// - Lower termination bits pick 100/110/75/120 ohm.
// - Termination upper bit set means external resistors.
// - Termination field lives at address 032h.
// - Decode B8ZS for REGION_VARIANT_SELECT, HDB3 E1, or AMI.
// - Bipolar violation insertion only under AMI.
// - REGION_VARIANT_SELECT rate conversion; any mode 8.192 bus.
`timescale 1ns/10ps
module lmc_line_mode_config
    import lmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_cs_n,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    output lmc_family_t family,
    output lmc_frame_t frame_format,
    output logic fmt_reserved,
    output logic int_match_en,
    output logic [1:0] term_ohms_sel,
    output lmc_code_t rx_line_code,
    output lmc_code_t tx_line_code,
    output logic tx_bpv_insert_en,
    output logic rate_convert_en,
    output logic bus_mux_en
);

    // Family decode from the carrier and region bits, shared by outputs and status.
    function automatic lmc_family_t family_of(input logic [7:0] mode);
        if (!mode[LMC_MODE_FAMILY_BIT]) begin
            family_of = LMC_E1;
        end else if (mode[LMC_MODE_REGION_BIT]) begin
            family_of = LMC_J1;
        end else begin
            family_of = LMC_T1;
        end
    endfunction

    function automatic logic [1:0] family_code(input lmc_family_t fam);
        case (fam)
            LMC_T1: family_code = LMC_FAM_CODE_T1;
            LMC_J1: family_code = LMC_FAM_CODE_J1;
            default: family_code = LMC_FAM_CODE_E1;
        endcase
    endfunction

    // One address decode serves the write and the read side, so the two can
    // never disagree about which register a byte address names.
    typedef enum logic [2:0] {LMC_SEL_NONE, LMC_SEL_MODE, LMC_SEL_TERM, LMC_SEL_LINE, LMC_SEL_STAT} lmc_sel_t;

    function automatic lmc_sel_t reg_sel(input logic [7:0] addr);
        case (addr)
            LMC_ADDR_MODE: reg_sel = LMC_SEL_MODE;
            LMC_ADDR_TERM: reg_sel = LMC_SEL_TERM;
            LMC_ADDR_LINE: reg_sel = LMC_SEL_LINE;
            LMC_ADDR_STAT: reg_sel = LMC_SEL_STAT;
            default: reg_sel = LMC_SEL_NONE;
        endcase
    endfunction

    // Receive and transmit take one line-code choice, so the two directions
    // can never run different rules; AMI overrides the family default.
    function automatic lmc_code_t code_of(input logic ami, input lmc_family_t fam);
        if (ami) begin
            code_of = LMC_CODE_AMI;
        end else if (fam == LMC_E1) begin
            code_of = LMC_CODE_HDB3;
        end else begin
            code_of = LMC_CODE_B8ZS;
        end
    endfunction

    // Host pins are asynchronous, so every one passes two flops first.
    logic [18:0] pin_raw;
    logic [18:0] pin_sync;
    logic cs_s;
    logic wr_s;
    logic rd_s;
    logic [7:0] addr_s;
    logic [7:0] data_s;

    assign pin_raw = {host_cs_n, host_wr_n, host_rd_n, host_addr, host_data_in};

    // The synchroniser resets to the idle pin levels, so the write edge detector
    // sees no false rising strobe straight after reset.
    lmc_sync2 #(
        .WIDTH(19),
        .RESET_VAL(LMC_PIN_IDLE)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(pin_raw),
        .q(pin_sync)
    );

    assign cs_s = pin_sync[18];
    assign wr_s = pin_sync[17];
    assign rd_s = pin_sync[16];
    assign addr_s = pin_sync[15:8];
    assign data_s = pin_sync[7:0];

    // Register file group.
    logic wr_prev_reg;
    logic wr_prev_next;
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [7:0] term_reg;
    logic [7:0] term_next;
    logic [7:0] line_reg;
    logic [7:0] line_next;
    logic wr_commit;

    // A write lands on the rising edge of the write strobe, so the address and
    // data the host holds across the whole strobe are the ones taken.
    always_comb begin
        wr_prev_next = wr_s;
        wr_commit = !cs_s && wr_s && !wr_prev_reg;
        mode_next = mode_reg;
        term_next = term_reg;
        line_next = line_reg;
        if (wr_commit) begin
            case (reg_sel(addr_s))
                LMC_SEL_MODE: mode_next = data_s & LMC_MODE_MASK;
                LMC_SEL_TERM: term_next = data_s & LMC_TERM_MASK;
                LMC_SEL_LINE: line_next = data_s & LMC_LINE_MASK;
                default: ;
            endcase
        end
    end

    // All control fields reset to zero: E1, internal matching at 100 ohm and the
    // family's own line code, which is the safest state for an unconfigured line.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_prev_reg <= 1'b1;
            mode_reg <= LMC_MODE_RST;
            term_reg <= LMC_TERM_RST;
            line_reg <= LMC_LINE_RST;
        end else begin
            wr_prev_reg <= wr_prev_next;
            mode_reg <= mode_next;
            term_reg <= term_next;
            line_reg <= line_next;
        end
    end

    // Decoded configuration group.
    lmc_family_t family_reg;
    lmc_family_t family_next;
    lmc_frame_t frame_reg;
    lmc_frame_t frame_next;
    logic rsvd_reg;
    logic rsvd_next;
    logic intm_reg;
    logic intm_next;
    logic [1:0] ohms_reg;
    logic [1:0] ohms_next;
    lmc_code_t rx_code_reg;
    lmc_code_t rx_code_next;
    lmc_code_t tx_code_reg;
    lmc_code_t tx_code_next;
    logic bpv_reg;
    logic bpv_next;
    logic rate_reg;
    logic rate_next;
    logic bus_reg;
    logic bus_next;
    logic [1:0] fmt_field;
    logic ami_sel;

    always_comb begin
        fmt_field = mode_reg[LMC_MODE_FMT_LSB +: 2];
        ami_sel = line_reg[LMC_LINE_AMI_BIT];
        family_next = family_of(mode_reg);
        frame_next = LMC_FR_NONE;
        rsvd_next = 1'b0;
        // The format field only has meaning once the family is known, so frame
        // decode follows the family choice rather than the raw bits.
        case (family_next)
            LMC_T1: begin
                case (fmt_field)
                    LMC_FMT_SF: frame_next = LMC_FR_SF;
                    LMC_FMT_ESF: frame_next = LMC_FR_ESF;
                    LMC_FMT_DM: frame_next = LMC_FR_DM;
                    default: frame_next = LMC_FR_SLC96;
                endcase
            end
            LMC_J1: begin
                // Reserved formats leave the framer idle rather than guess a format.
                case (fmt_field)
                    LMC_FMT_SF: frame_next = LMC_FR_SF;
                    LMC_FMT_ESF: frame_next = LMC_FR_ESF;
                    default: rsvd_next = 1'b1;
                endcase
            end
            default: frame_next = LMC_FR_NONE;
        endcase
        // The resistor select passes through even with external matching, so
        // software can stage a value before it turns internal matching on.
        intm_next = !term_reg[LMC_TERM_EXT_BIT];
        ohms_next = term_reg[LMC_TERM_SEL_LSB +: 2];
        rx_code_next = code_of(ami_sel, family_next);
        tx_code_next = code_of(ami_sel, family_next);
        // Violation insertion is gated by AMI here, so a stale insert bit cannot
        // corrupt a B8ZS or HDB3 line after software changes the line code.
        bpv_next = ami_sel && line_reg[LMC_LINE_BPV_BIT];
        // Rate conversion means nothing on an E1 stream, so it is forced off there;
        // the bus multiplexer works in every family.
        rate_next = line_reg[LMC_LINE_RATE_BIT] && (family_next != LMC_E1);
        bus_next = line_reg[LMC_LINE_BUS_BIT];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            family_reg <= LMC_E1;
            frame_reg <= LMC_FR_NONE;
            rsvd_reg <= 1'b0;
            intm_reg <= 1'b1;
            ohms_reg <= 2'h0;
            rx_code_reg <= LMC_CODE_HDB3;
            tx_code_reg <= LMC_CODE_HDB3;
            bpv_reg <= 1'b0;
            rate_reg <= 1'b0;
            bus_reg <= 1'b0;
        end else begin
            family_reg <= family_next;
            frame_reg <= frame_next;
            rsvd_reg <= rsvd_next;
            intm_reg <= intm_next;
            ohms_reg <= ohms_next;
            rx_code_reg <= rx_code_next;
            tx_code_reg <= tx_code_next;
            bpv_reg <= bpv_next;
            rate_reg <= rate_next;
            bus_reg <= bus_next;
        end
    end

    // Read port group. Family and format bits of the status come straight from the
    // mode register, while the reserved and matching bits come from the decode stage,
    // so a read in the cycle right after a write may see them one clock apart.
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic oe_n_reg;
    logic oe_n_next;
    logic [7:0] stat_word;

    always_comb begin
        stat_word = 8'h00;
        stat_word[LMC_STAT_FAM_LSB +: 2] = family_code(family_of(mode_reg));
        stat_word[LMC_STAT_FMT_LSB +: 2] = mode_reg[LMC_MODE_FMT_LSB +: 2];
        stat_word[LMC_STAT_RSVD_BIT] = rsvd_reg;
        stat_word[LMC_STAT_INTM_BIT] = intm_reg;
        oe_n_next = !(!cs_s && !rd_s);
        rdata_next = 8'h00;
        if (!oe_n_next) begin
            case (reg_sel(addr_s))
                LMC_SEL_MODE: rdata_next = mode_reg;
                LMC_SEL_TERM: rdata_next = term_reg;
                LMC_SEL_LINE: rdata_next = line_reg;
                LMC_SEL_STAT: rdata_next = stat_word;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            oe_n_reg <= 1'b1;
        end else begin
            rdata_reg <= rdata_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign host_data_out = rdata_reg;
    assign host_data_oe_n = oe_n_reg;
    assign family = family_reg;
    assign frame_format = frame_reg;
    assign fmt_reserved = rsvd_reg;
    assign int_match_en = intm_reg;
    assign term_ohms_sel = ohms_reg;
    assign rx_line_code = rx_code_reg;
    assign tx_line_code = tx_code_reg;
    assign tx_bpv_insert_en = bpv_reg;
    assign rate_convert_en = rate_reg;
    assign bus_mux_en = bus_reg;

endmodule // lmc_line_mode_config

// >>> dv/lmc_line_mode_config_sva.sv
`timescale 1ns/10ps
module lmc_line_mode_config_sva
    import lmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe_n,
    input wire lmc_family_t family,
    input wire lmc_frame_t frame_format,
    input wire logic fmt_reserved,
    input wire lmc_code_t rx_line_code,
    input wire lmc_code_t tx_line_code,
    input wire logic tx_bpv_insert_en,
    input wire logic rate_convert_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Long enough to cover the strobe synchroniser plus the decode stage.
    sequence wr_quiet_s; host_wr_n [*8]; endsequence
    sequence rd_quiet_s; host_rd_n [*4]; endsequence
    e1_no_frame_a:
        assert property (family == LMC_E1 |-> frame_format == LMC_FR_NONE) else $error("frame set in E1");
    j1_frame_limit_a:
        assert property (family == LMC_J1 |-> frame_format inside {LMC_FR_NONE, LMC_FR_SF, LMC_FR_ESF})
        else $error("bad J1 frame");
    rsvd_flag_a:
        assert property (fmt_reserved |-> family == LMC_J1 && frame_format == LMC_FR_NONE) else $error("bad flag");
    code_pair_a:
        assert property (tx_line_code == rx_line_code) else $error("line codes differ");
    code_family_a:
        assert property (rx_line_code != LMC_CODE_AMI |-> (rx_line_code == LMC_CODE_HDB3) == (family == LMC_E1))
        else $error("code does not match family");
    bpv_ami_a:
        assert property (tx_bpv_insert_en |-> tx_line_code == LMC_CODE_AMI) else $error("bpv without AMI");
    rate_family_a:
        assert property (rate_convert_en |-> family != LMC_E1) else $error("rate convert in E1");
    cfg_hold_a:
        assert property (wr_quiet_s |-> $stable(family) && $stable(frame_format)) else $error("mode moved");
    rd_release_a:
        assert property (rd_quiet_s |-> host_data_oe_n && host_data_out == 8'h00) else $error("bus driven");
endmodule // lmc_line_mode_config_sva
bind lmc_line_mode_config lmc_line_mode_config_sva lmc_line_mode_config_sva_inst (.clk, .rst_n, .host_wr_n,
    .host_rd_n, .host_data_out, .host_data_oe_n, .family, .frame_format, .fmt_reserved, .rx_line_code,
    .tx_line_code, .tx_bpv_insert_en, .rate_convert_en);

// >>> dv/lmc_host_model.sv
`timescale 1ns/10ps
module lmc_host_model (
    input wire logic clk,
    output logic host_cs_n,
    output logic host_wr_n,
    output logic host_rd_n,
    output logic [7:0] host_addr,
    output logic [7:0] host_data_in
);
    initial begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_addr = 8'h00;
        host_data_in = 8'h00;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Released lines flip so a late sample by the device cannot pass by luck.
    task automatic release_bus();
        host_cs_n = 1'b1;
        host_addr = ~host_addr;
        host_data_in = ~host_data_in;
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        host_cs_n = 1'b0;
        host_addr = a;
        host_data_in = d;
        host_wr_n = 1'b0;
        idle(3);
        host_wr_n = 1'b1;
        idle(4);
        release_bus();
        idle(3);
    endtask
    task automatic bus_read(input logic [7:0] a);
        @(negedge clk);
        host_cs_n = 1'b0;
        host_addr = a;
        host_rd_n = 1'b0;
        idle(4);
    endtask
    task automatic bus_end_read();
        host_rd_n = 1'b1;
        release_bus();
        idle(4);
    endtask
endmodule // lmc_host_model

// >>> dv/test_lmc_line_mode_config.sv
`timescale 1ns/10ps
module test_lmc_line_mode_config
    import lmc_pkg::*;
;
    logic clk, rst_n, host_cs_n, host_wr_n, host_rd_n, host_data_oe_n, fmt_reserved, int_match_en;
    logic tx_bpv_insert_en, rate_convert_en, bus_mux_en;
    logic [7:0] host_addr, host_data_in, host_data_out;
    logic [1:0] term_ohms_sel;
    lmc_family_t family;
    lmc_frame_t frame_format;
    lmc_code_t rx_line_code, tx_line_code;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    lmc_line_mode_config lmc_line_mode_config_inst (.clk, .rst_n, .host_cs_n, .host_wr_n, .host_rd_n, .host_addr,
        .host_data_in, .host_data_out, .host_data_oe_n, .family, .frame_format, .fmt_reserved, .int_match_en,
        .term_ohms_sel, .rx_line_code, .tx_line_code, .tx_bpv_insert_en, .rate_convert_en, .bus_mux_en);
    lmc_host_model lmc_host_model_inst (.clk, .host_cs_n, .host_wr_n, .host_rd_n, .host_addr, .host_data_in);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        lmc_host_model_inst.bus_read(a);
        check(host_data_out, exp);
        check({7'h00, host_data_oe_n}, 8'h00);
        lmc_host_model_inst.bus_end_read();
        check({7'h00, host_data_oe_n}, 8'h01);
    endtask
    task automatic t_modes();
        logic [7:0] fam, rsv;
        for (int v = 0; v < 16; v++) begin
            lmc_host_model_inst.bus_write(LMC_ADDR_MODE, 8'(v) | 8'hF0);
            fam = !v[0] ? 8'h00 : (v[1] ? 8'h02 : 8'h01);
            rsv = (v[0] && v[1] && v[3]) ? 8'h01 : 8'h00;
            check(8'(family), fam);
            check(8'(frame_format), (v[0] && rsv == 8'h00) ? 8'(v[3:2]) + 8'h01 : 8'h00);
            check({7'h00, fmt_reserved}, rsv);
            rd_check(LMC_ADDR_MODE, 8'(v));
            rd_check(LMC_ADDR_STAT, fam | 8'(v & 12) | (rsv << 5) | 8'h40);
        end
    endtask
    task automatic t_term();
        for (int v = 0; v < 8; v++) begin
            lmc_host_model_inst.bus_write(LMC_ADDR_TERM, 8'(v) | 8'hF8);
            check({7'h00, int_match_en}, 8'(!v[2]));
            check({6'h00, term_ohms_sel}, 8'(v & 3));
            rd_check(LMC_ADDR_TERM, 8'(v));
        end
        lmc_host_model_inst.bus_write(LMC_ADDR_TERM, 8'h00);
    endtask
    task automatic t_line();
        // Modes E1, T1, E1 with the region bit set, and J1.
        for (int m = 0; m < 4; m++) begin
            for (int l = 0; l < 16; l++) begin
                lmc_host_model_inst.bus_write(LMC_ADDR_MODE, 8'(m));
                lmc_host_model_inst.bus_write(LMC_ADDR_LINE, 8'(l));
                check(8'(rx_line_code), l[0] ? 8'h00 : (m[0] ? 8'h01 : 8'h02));
                check(8'(tx_line_code), l[0] ? 8'h00 : (m[0] ? 8'h01 : 8'h02));
                check({7'h00, tx_bpv_insert_en}, 8'(l[0] & l[1]));
                check({7'h00, rate_convert_en}, 8'(l[2] & m[0]));
                check({7'h00, bus_mux_en}, 8'(l[3]));
            end
        end
    endtask
    // Status is read-only and 55h is unmapped; neither write may disturb the J1 mode left by t_line.
    task automatic t_refuse();
        lmc_host_model_inst.bus_write(LMC_ADDR_STAT, 8'hFF);
        lmc_host_model_inst.bus_write(8'h55, 8'hFF);
        rd_check(8'h55, 8'h00);
        rd_check(LMC_ADDR_STAT, 8'h42);
        check(8'(family), 8'h02);
    endtask
    // Reset at the start, and again at the end of the run with J1 and all line options set, must restore idle outputs.
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        check(8'(family), 8'h00);
        check(8'(frame_format), 8'h00);
        check({7'h00, fmt_reserved}, 8'h00);
        check(8'(rx_line_code), 8'h02);
        check(8'(tx_line_code), 8'h02);
        check({7'h00, int_match_en}, 8'h01);
        check({6'h00, term_ohms_sel}, 8'h00);
        check({7'h00, tx_bpv_insert_en}, 8'h00);
        check({6'h00, rate_convert_en, bus_mux_en}, 8'h00);
        check({7'h00, host_data_oe_n}, 8'h01);
        check(host_data_out, 8'h00);
        rd_check(LMC_ADDR_LINE, 8'h00);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        t_reset();
        t_modes();
        t_term();
        t_line();
        t_refuse();
        t_reset();
        give_verdict();
    end
endmodule // test_lmc_line_mode_config
